//--- shared/mio_pkg.sv
/*
 * constants for the misc i/o configuration bank: register indexes,
 * field positions, reset values and the bus handshake states.
 * assumes a classic wishbone slave with 32-bit data and byte addresses.
 */
package mio_pkg;

	// ==========================================================
	// register indexes (byte address is four times the index)
	localparam logic [13:0] IDX_STATE_COUNT = 14'h2002;
	localparam logic [13:0] IDX_CPU_DIV     = 14'h2004;
	localparam logic [13:0] IDX_SELECTOR    = 14'h2005;
	localparam logic [13:0] IDX_OPTICAL     = 14'h2008;
	localparam logic [13:0] IDX_PIN_ALLOC   = 14'h2010;
	localparam logic [13:0] IDX_SEG_FIRST   = 14'h2030;
	localparam logic [13:0] IDX_SEG_LAST    = 14'h2059;

	// ==========================================================
	// field positions
	localparam int POS_STATE_COUNT = 6;
	localparam int POS_CPU_DIV     = 0;
	localparam int POS_ALT_SET     = 2;
	localparam int POS_SYNC_EN     = 0;
	localparam int POS_OPT_DIS     = 5;
	localparam int POS_PIN_ALLOC   = 0;

	// ==========================================================
	// values after reset
	localparam logic [1:0] RST_STATE_COUNT = 2'h0;
	localparam logic [2:0] RST_CPU_DIV     = 3'h0;
	localparam logic       RST_ALT_SET     = 1'h0;
	localparam logic       RST_SYNC_EN     = 1'h0;
	localparam logic       RST_OPT_DIS     = 1'h0;
	localparam logic [4:0] RST_PIN_ALLOC   = 5'h0;

	// ==========================================================
	// counts
	localparam int SEG_COUNT     = 42;
	localparam int GPIO_COUNT    = 22;
	localparam int GPIO_FIRST    = 4;
	localparam int PIN_ALLOC_MAX = 18;
	localparam int SYNC_SEGMENT  = 7;
	localparam int DIV_MAX_LOG   = 7;

	// ==========================================================
	// bus handshake states, gray from idle to read to ack; ack back to idle flips both bits
	typedef enum logic [1:0] {
		MIO_BUS_IDLE = 2'h0,
		MIO_BUS_READ = 2'h1,
		MIO_BUS_ACK  = 2'h3
	} mio_bus_e;

endpackage

//--- rtl/mio_segment_ram.sv
/*
 * small memory for the segment data words: one write port and two
 * registered read ports (bus side and lcd side).
 * assumes writes and reads on the single system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module mio_segment_ram #(
	parameter int DEPTH = 42,
	parameter int WIDTH = 4,
	parameter int AW    = 6
) (
	// clock
	input  wire logic             clk_i,
	// write port
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	// bus read port
	input  wire logic [AW-1:0]    baddr_i,
	output logic      [WIDTH-1:0] bdata_o,
	// lcd read port
	input  wire logic [AW-1:0]    laddr_i,
	output logic      [WIDTH-1:0] ldata_o
);

	logic [WIDTH-1:0] mem [DEPTH];

	// write, ignoring addresses past the end
	always_ff @(posedge clk_i) begin
		if (we_i && (int'(waddr_i) < DEPTH)) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// registered reads, zero past the end
	always_ff @(posedge clk_i) begin
		bdata_o <= (int'(baddr_i) < DEPTH) ? mem[baddr_i] : '0;
		ldata_o <= (int'(laddr_i) < DEPTH) ? mem[laddr_i] : '0;
	end

endmodule

`default_nettype wire

//--- rtl/mio_cpu_clock_divider.sv
/*
 * processor clock enable: divides the compute-engine clock by a power
 * of two as one-cycle enable pulses; a new ratio is taken only at the
 * end of a period so the pulse train never glitches or stops.
 * assumes clk_i is the compute-engine clock.
 */
`timescale 1ns/1ps
`default_nettype none

module mio_cpu_clock_divider #(
	parameter int LOG_MAX = 7
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// requested ratio as a power of two
	input  wire logic [2:0] div_i,
	// outputs
	output logic            cpu_clock_enable_o,
	output logic      [2:0] active_div_o
);

	logic [LOG_MAX-1:0] cnt;
	logic [LOG_MAX-1:0] mask;
	logic               period_end;

	// low bits that must all be ones for a pulse
	assign mask       = LOG_MAX'((1 << active_div_o) - 1);
	assign period_end = ((cnt & mask) == mask);
	assign cpu_clock_enable_o = period_end;

	// free-running count of compute-engine cycles
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + LOG_MAX'(1);
		end
	end

	// ratio switches only at a period boundary
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_div_o <= mio_pkg::RST_CPU_DIV;
		end else if (period_end) begin
			active_div_o <= div_i;
		end
	end

endmodule

`default_nettype wire

//--- rtl/mio_config_bank.sv
/*
 * misc i/o configuration bank: segment data words, pin allocation,
 * processor clock divider, input selector options and the optical
 * transmit tristate, reached over a classic wishbone slave.
 * assumes one 200 MHz clock and a synchronous active-high reset.
 */
// Chosen here: register access over Wishbone.
// Behaviour
// - segment words four bits, bit0 first common
// - cpu clock is engine clock over two-power
// - divider rewritable anytime, switch glitch-free, no stall
// - divider field resets to zero
// - alternate set bit selects alternate inputs
// - state count code gives six/four/three/two
// - sync enable turns segment seven into sync
// - transmit disable tristates optical transmit pin
// - allocation setting trades i/o pins for segments
`timescale 1ns/1ps
`default_nettype none

module mio_config_bank #(
	parameter int SEG_COUNT  = mio_pkg::SEG_COUNT,
	parameter int GPIO_COUNT = mio_pkg::GPIO_COUNT
) (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// wishbone slave
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [15:0]           adr_i,
	input  wire logic [3:0]            sel_i,
	input  wire logic [31:0]           dat_i,
	output logic      [31:0]           dat_o,
	output logic                       ack_o,
	// processor clock enable
	output logic                       cpu_clock_enable_o,
	// input selector
	output logic                       input_selector_alternate_set_o,
	output logic      [2:0]            input_selector_states_o,
	input  wire logic                  selector_sync_pulse_i,
	// lcd side
	input  wire logic [5:0]            lcd_seg_index_i,
	input  wire logic [1:0]            lcd_commons_used_i,
	output logic      [3:0]            lcd_seg_data_o,
	input  wire logic                  segment_pin_seven_lcd_i,
	output logic                       segment_pin_seven_o,
	// pin allocation
	output logic      [SEG_COUNT-1:0]  segment_pin_enable_o,
	output logic      [GPIO_COUNT-1:0] general_purpose_pin_enable_o,
	// optical transmit
	input  wire logic                  optical_tx_data_i,
	output logic                       optical_transmit_pin_o,
	output logic                       optical_transmit_pin_oe_o
);

	// ==========================================================
	// helpers

	// states per selector cycle from the two-bit code
	function automatic logic [2:0] states_of(input logic [1:0] code);
		logic [2:0] n;
		n = 3'h6;
		unique case (code)
			2'h0: n = 3'h6;
			2'h1: n = 3'h4;
			2'h2: n = 3'h3;
			2'h3: n = 3'h2;
		endcase
		return n;
	endfunction

	// allocation setting held to its top value
	function automatic int alloc_of(input logic [4:0] s);
		return (int'(s) > mio_pkg::PIN_ALLOC_MAX) ?
			mio_pkg::PIN_ALLOC_MAX : int'(s);
	endfunction

	// ==========================================================
	// state

	mio_pkg::mio_bus_e bus_state;
	mio_pkg::mio_bus_e next_bus_state;

	logic [1:0]  state_count;
	logic [2:0]  cpu_clock_divider;
	logic        input_selector_alternate_set;
	logic        selector_sync_output_enable;
	logic        optical_transmit_disable;
	logic [4:0]  pin_alloc;

	logic [13:0] idx;
	logic        req;
	logic        wr_ok;
	logic        seg_hit;
	logic [5:0]  seg_addr;
	logic [3:0]  seg_bus_data;
	logic [3:0]  seg_lcd_data;
	logic [31:0] next_dat;
	logic [3:0]  com_mask;
	int          alloc;

	// ==========================================================
	// address decode

	// register offsets are word indexes
	assign idx     = adr_i[15:2];
	assign req     = cyc_i && stb_i;
	assign seg_hit = (idx >= mio_pkg::IDX_SEG_FIRST) &&
		(idx <= mio_pkg::IDX_SEG_LAST);
	assign seg_addr = 6'(idx - mio_pkg::IDX_SEG_FIRST);

	// write acts on the acking edge, low lane only
	assign wr_ok = (bus_state == mio_pkg::MIO_BUS_ACK) &&
		req && we_i && sel_i[0];

	// ==========================================================
	// bus handshake

	// one wait cycle for the registered memory read
	always_comb begin
		next_bus_state = bus_state;
		unique case (bus_state)
			mio_pkg::MIO_BUS_IDLE: begin
				if (req) begin
					next_bus_state = mio_pkg::MIO_BUS_READ;
				end
			end
			mio_pkg::MIO_BUS_READ: begin
				if (req) begin
					next_bus_state = mio_pkg::MIO_BUS_ACK;
				end else begin
					next_bus_state = mio_pkg::MIO_BUS_IDLE;
				end
			end
			mio_pkg::MIO_BUS_ACK: begin
				next_bus_state = mio_pkg::MIO_BUS_IDLE;
			end
			default: begin
				next_bus_state = mio_pkg::MIO_BUS_IDLE;
			end
		endcase
	end

	// handshake state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_state <= mio_pkg::MIO_BUS_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	// ack is one cycle, in the ack state
	assign ack_o = (bus_state == mio_pkg::MIO_BUS_ACK);

	// ==========================================================
	// read data

	// read mux, unmapped reads give zero
	always_comb begin
		next_dat = 32'h0;
		if (seg_hit) begin
			next_dat[3:0] = seg_bus_data;
		end else begin
			unique case (idx)
				mio_pkg::IDX_STATE_COUNT:
					next_dat[mio_pkg::POS_STATE_COUNT +: 2] = state_count;
				mio_pkg::IDX_CPU_DIV:
					next_dat[mio_pkg::POS_CPU_DIV +: 3] = cpu_clock_divider;
				mio_pkg::IDX_SELECTOR: begin
					next_dat[mio_pkg::POS_ALT_SET] =
						input_selector_alternate_set;
					next_dat[mio_pkg::POS_SYNC_EN] =
						selector_sync_output_enable;
				end
				mio_pkg::IDX_OPTICAL:
					next_dat[mio_pkg::POS_OPT_DIS] = optical_transmit_disable;
				mio_pkg::IDX_PIN_ALLOC:
					next_dat[mio_pkg::POS_PIN_ALLOC +: 5] = pin_alloc;
				default:
					next_dat = 32'h0;
			endcase
		end
	end

	// read data registered with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0;
		end else if (bus_state == mio_pkg::MIO_BUS_READ) begin
			dat_o <= we_i ? 32'h0 : next_dat;
		end else if (bus_state == mio_pkg::MIO_BUS_ACK) begin
			dat_o <= 32'h0;
		end
	end

	// ==========================================================
	// control registers

	// input selector state count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_count <= mio_pkg::RST_STATE_COUNT;
		end else if (wr_ok && idx == mio_pkg::IDX_STATE_COUNT) begin
			state_count <= dat_i[mio_pkg::POS_STATE_COUNT +: 2];
		end
	end

	// processor clock divider field
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_clock_divider <= mio_pkg::RST_CPU_DIV;
		end else if (wr_ok && idx == mio_pkg::IDX_CPU_DIV) begin
			cpu_clock_divider <= dat_i[mio_pkg::POS_CPU_DIV +: 3];
		end
	end

	// selector alternate set and sync enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			input_selector_alternate_set <= mio_pkg::RST_ALT_SET;
			selector_sync_output_enable  <= mio_pkg::RST_SYNC_EN;
		end else if (wr_ok && idx == mio_pkg::IDX_SELECTOR) begin
			input_selector_alternate_set <= dat_i[mio_pkg::POS_ALT_SET];
			selector_sync_output_enable  <= dat_i[mio_pkg::POS_SYNC_EN];
		end
	end

	// optical transmit disable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			optical_transmit_disable <= mio_pkg::RST_OPT_DIS;
		end else if (wr_ok && idx == mio_pkg::IDX_OPTICAL) begin
			optical_transmit_disable <= dat_i[mio_pkg::POS_OPT_DIS];
		end
	end

	// pin allocation setting
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_alloc <= mio_pkg::RST_PIN_ALLOC;
		end else if (wr_ok && idx == mio_pkg::IDX_PIN_ALLOC) begin
			pin_alloc <= dat_i[mio_pkg::POS_PIN_ALLOC +: 5];
		end
	end

	// ==========================================================
	// segment data memory

	mio_segment_ram #(
		.DEPTH (SEG_COUNT),
		.WIDTH (4),
		.AW    (6)
	) u_seg_ram (
		.clk_i   (clk_i),
		.we_i    (wr_ok && seg_hit),
		.waddr_i (seg_addr),
		.wdata_i (dat_i[3:0]),
		.baddr_i (seg_addr),
		.bdata_o (seg_bus_data),
		.laddr_i (lcd_seg_index_i),
		.ldata_o (seg_lcd_data)
	);

	// bit n is common plane n; unused commons masked off
	always_comb begin
		com_mask = 4'h0;
		unique case (lcd_commons_used_i)
			2'h0: com_mask = 4'h1;
			2'h1: com_mask = 4'h3;
			2'h2: com_mask = 4'h7;
			2'h3: com_mask = 4'hF;
		endcase
	end

	// registered lcd word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lcd_seg_data_o <= 4'h0;
		end else begin
			lcd_seg_data_o <= seg_lcd_data & com_mask;
		end
	end

	// ==========================================================
	// processor clock enable

	mio_cpu_clock_divider #(
		.LOG_MAX (mio_pkg::DIV_MAX_LOG)
	) u_cpu_div (
		.clk_i              (clk_i),
		.rst_i              (rst_i),
		.div_i              (cpu_clock_divider),
		.cpu_clock_enable_o (cpu_clock_enable_o),
		.active_div_o       ()
	);

	// ==========================================================
	// input selector outputs

	// selector option outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			input_selector_alternate_set_o <= mio_pkg::RST_ALT_SET;
			input_selector_states_o        <= 3'h6;
		end else begin
			input_selector_alternate_set_o <=
				input_selector_alternate_set;
			input_selector_states_o <= states_of(state_count);
		end
	end

	// segment seven becomes sync output when enabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			segment_pin_seven_o <= 1'h0;
		end else if (selector_sync_output_enable) begin
			segment_pin_seven_o <= selector_sync_pulse_i;
		end else begin
			segment_pin_seven_o <= segment_pin_seven_lcd_i;
		end
	end

	// ==========================================================
	// pin allocation

	assign alloc = alloc_of(pin_alloc);

	// segments 42-n..41 and i/o 4..21-n
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			segment_pin_enable_o         <= '0;
			general_purpose_pin_enable_o <= '0;
		end else begin
			for (int i = 0; i < SEG_COUNT; i++) begin
				segment_pin_enable_o[i] <=
					(i >= SEG_COUNT - alloc);
			end
			for (int k = 0; k < GPIO_COUNT; k++) begin
				general_purpose_pin_enable_o[k] <=
					(k >= mio_pkg::GPIO_FIRST) &&
					(k <= GPIO_COUNT - 1 - alloc);
			end
		end
	end

	// ==========================================================
	// optical transmit pin

	// data out registered, enable off while disabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			optical_transmit_pin_o    <= 1'h0;
			optical_transmit_pin_oe_o <= 1'h0;
		end else begin
			optical_transmit_pin_o    <= optical_tx_data_i;
			optical_transmit_pin_oe_o <= !optical_transmit_disable;
		end
	end

endmodule

`default_nettype wire

//--- sim/mio_config_bank_props.sv
/*
 * checker for the config bank: bus handshake, field driven outputs and
 * the processor clock enable, judged against shadows of bus writes.
 * assumes it sees only the top ports, bound in below.
 */
`timescale 1ns/1ps
`default_nettype none
module mio_config_bank_props #(
	parameter int SEG_COUNT  = 42,
	parameter int GPIO_COUNT = 22
) (
	// clock, reset, bus
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  cyc_i,
	input wire logic                  stb_i,
	input wire logic                  we_i,
	input wire logic [15:0]           adr_i,
	input wire logic [3:0]            sel_i,
	input wire logic [31:0]           dat_i,
	input wire logic [31:0]           dat_o,
	input wire logic                  ack_o,
	// side ports
	input wire logic                  cpu_clock_enable_o,
	input wire logic                  input_selector_alternate_set_o,
	input wire logic [2:0]            input_selector_states_o,
	input wire logic                  selector_sync_pulse_i,
	input wire logic                  segment_pin_seven_lcd_i,
	input wire logic                  segment_pin_seven_o,
	input wire logic [SEG_COUNT-1:0]  segment_pin_enable_o,
	input wire logic [GPIO_COUNT-1:0] general_purpose_pin_enable_o,
	input wire logic                  optical_tx_data_i,
	input wire logic                  optical_transmit_pin_o,
	input wire logic                  optical_transmit_pin_oe_o
);
	// ====
	// shadows of written fields
	logic [1:0]            sc;
	logic [2:0]            dv;
	logic                  alt, syn, dis;
	logic [4:0]            al;
	logic [8:0]            quiet;
	logic [7:0]            gap;
	logic [SEG_COUNT-1:0]  seg_exp;
	logic [GPIO_COUNT-1:0] gp_exp;
	int                    n;
	wire                   wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
	wire                   settled = quiet >= 9'h003 && !ack_o;
	wire [13:0]            idx = adr_i[15:2];

	// capture accepted writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{sc, dv, alt, syn, dis, al} <= '0;
		end else if (wr) begin
			if (idx == mio_pkg::IDX_STATE_COUNT) sc <= dat_i[7:6];
			if (idx == mio_pkg::IDX_CPU_DIV) dv <= dat_i[2:0];
			if (idx == mio_pkg::IDX_SELECTOR) {alt, syn} <= {dat_i[2], dat_i[0]};
			if (idx == mio_pkg::IDX_OPTICAL) dis <= dat_i[5];
			if (idx == mio_pkg::IDX_PIN_ALLOC) al <= dat_i[4:0];
		end
	end

	// cycles since last ack, and low cycles since last enable pulse
	always_ff @(posedge clk_i) begin
		quiet <= (rst_i || ack_o) ? 9'h000 : quiet + 9'(quiet != 9'h1FF);
		gap <= (rst_i || cpu_clock_enable_o) ? 8'h00 : gap + 8'(gap != 8'hFF);
	end

	// expected pin allocation masks
	always_comb begin
		n = (al > 5'h12) ? 18 : int'(al);
		for (int i = 0; i < SEG_COUNT; i++) seg_exp[i] = i >= SEG_COUNT - n;
		for (int k = 0; k < GPIO_COUNT; k++) gp_exp[k] = k >= 4 && k <= GPIO_COUNT - 1 - n;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	a_ack_cause: assert property (ack_o |-> cyc_i && stb_i && $past(cyc_i && stb_i))
		else $error("ack without request");
	a_opt_tristate: assert property (settled |-> optical_transmit_pin_oe_o == !dis)
		else $error("optical enable wrong");
	a_opt_data: assert property (settled |-> optical_transmit_pin_o == $past(optical_tx_data_i))
		else $error("optical data wrong");
	a_states_map: assert property (settled |-> input_selector_states_o ==
		((sc == 2'h0) ? 3'h6 : (sc == 2'h1) ? 3'h4 : (sc == 2'h2) ? 3'h3 : 3'h2))
		else $error("state count wrong");
	a_alt_copy: assert property (settled |-> input_selector_alternate_set_o == alt)
		else $error("alternate set wrong");
	a_seven_route: assert property (settled |-> segment_pin_seven_o == (syn ?
		$past(selector_sync_pulse_i) : $past(segment_pin_seven_lcd_i)))
		else $error("segment seven wrong");
	a_alloc_pins: assert property (settled |-> segment_pin_enable_o == seg_exp &&
		general_purpose_pin_enable_o == gp_exp) else $error("pin allocation wrong");
	a_div_steady: assert property (quiet >= 9'h090 && dv == 3'h0 |-> cpu_clock_enable_o)
		else $error("undivided enable missing");
	a_div_ratio: assert property (quiet >= 9'h120 && cpu_clock_enable_o && dv != 3'h0 |->
		gap == (8'h01 << dv) - 8'h01) else $error("enable ratio wrong");
	a_gap_bound: assert property (gap <= 8'h7F) else $error("enable gap too long");

	c_write: cover property (ack_o && we_i);
	c_read: cover property (ack_o && !we_i);
	c_div_max: cover property (dv == 3'h7 && cpu_clock_enable_o);
endmodule

bind mio_config_bank mio_config_bank_props #(.SEG_COUNT(SEG_COUNT), .GPIO_COUNT(GPIO_COUNT))
	mio_config_bank_props_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.cpu_clock_enable_o(cpu_clock_enable_o),
	.input_selector_alternate_set_o(input_selector_alternate_set_o),
	.input_selector_states_o(input_selector_states_o),
	.selector_sync_pulse_i(selector_sync_pulse_i),
	.segment_pin_seven_lcd_i(segment_pin_seven_lcd_i),
	.segment_pin_seven_o(segment_pin_seven_o), .segment_pin_enable_o(segment_pin_enable_o),
	.general_purpose_pin_enable_o(general_purpose_pin_enable_o),
	.optical_tx_data_i(optical_tx_data_i), .optical_transmit_pin_o(optical_transmit_pin_o),
	.optical_transmit_pin_oe_o(optical_transmit_pin_oe_o));
`default_nettype wire

//--- sim/mio_config_bank_tb_top.sv
/*
 * self-checking bench for the config bank: wishbone master tasks, random
 * side inputs, read data scored through a queue of expectations.
 * assumes the checker is bound in from its own file.
 */
`timescale 1ns/1ps
`default_nettype none
module mio_config_bank_tb_top;
	// ====
	// signals
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, v;
	logic [15:0] adr_i;
	logic [3:0]  sel_i, lcd_seg_data_o, seg_mem [42];
	logic [31:0] dat_i, dat_o, exp_q [$];
	logic        cpu_clock_enable_o, input_selector_alternate_set_o, selector_sync_pulse_i;
	logic [2:0]  input_selector_states_o, st_tbl [4] = '{3'h6, 3'h4, 3'h3, 3'h2};
	logic [5:0]  lcd_seg_index_i;
	logic [1:0]  lcd_commons_used_i;
	logic        segment_pin_seven_lcd_i, segment_pin_seven_o, optical_tx_data_i;
	logic        optical_transmit_pin_o, optical_transmit_pin_oe_o;
	logic [41:0] segment_pin_enable_o, sm;
	logic [21:0] general_purpose_pin_enable_o, gm;
	int          num_errors, check_count, cycles, i, k, n;
	int          al_tbl [6] = '{0, 14, 15, 17, 18, 20};

	mio_config_bank #(.SEG_COUNT(42), .GPIO_COUNT(22)) mio_config_bank_i (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.cpu_clock_enable_o(cpu_clock_enable_o),
		.input_selector_alternate_set_o(input_selector_alternate_set_o),
		.input_selector_states_o(input_selector_states_o),
		.selector_sync_pulse_i(selector_sync_pulse_i),
		.lcd_seg_index_i(lcd_seg_index_i), .lcd_commons_used_i(lcd_commons_used_i),
		.lcd_seg_data_o(lcd_seg_data_o), .segment_pin_seven_lcd_i(segment_pin_seven_lcd_i),
		.segment_pin_seven_o(segment_pin_seven_o), .segment_pin_enable_o(segment_pin_enable_o),
		.general_purpose_pin_enable_o(general_purpose_pin_enable_o),
		.optical_tx_data_i(optical_tx_data_i), .optical_transmit_pin_o(optical_transmit_pin_o),
		.optical_transmit_pin_oe_o(optical_transmit_pin_oe_o));

	// clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// ====
	// tasks
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic bus(input logic w, input logic [13:0] idx, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {idx, 2'h0};
		dat_i <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [13:0] idx, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, idx, 32'h0);
	endtask

	task automatic settle;
		repeat (4) @(posedge clk_i);
	endtask

	task end_of_test;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// random side inputs, read scoring and hang guard
	always @(posedge clk_i) begin
		selector_sync_pulse_i <= 1'($urandom);
		segment_pin_seven_lcd_i <= 1'($urandom);
		optical_tx_data_i <= 1'($urandom);
		if (ack_o === 1'b1 && we_i === 1'b0) chk("read", dat_o, exp_q.pop_front());
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	// ====
	// main sequence
	initial begin
		void'($urandom(43));
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, lcd_seg_index_i, lcd_commons_used_i} = '0;
		{selector_sync_pulse_i, segment_pin_seven_lcd_i, optical_tx_data_i} = '0;
		sel_i = 4'hF;
		rst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		settle();
		chk("enable", cpu_clock_enable_o, 1);
		chk("oe", optical_transmit_pin_oe_o, 1);
		foreach (al_tbl[k]) rd(14'h2001 + 14'(k) * 14'h3, 32'h0);
		bus(1'b1, 14'h2001, 32'hFF);
		rd(14'h2001, 32'h0);
		// write with the low byte lane off is ignored
		sel_i <= 4'hE;
		bus(1'b1, mio_pkg::IDX_PIN_ALLOC, 32'h5);
		sel_i <= 4'hF;
		rd(mio_pkg::IDX_PIN_ALLOC, 32'h0);
		for (i = 0; i < 4; i++) begin
			bus(1'b1, mio_pkg::IDX_STATE_COUNT, 32'(i) << 6);
			settle();
			chk("states", input_selector_states_o, st_tbl[i]);
			rd(mio_pkg::IDX_STATE_COUNT, 32'(i) << 6);
			bus(1'b1, mio_pkg::IDX_SELECTOR, {29'h0, i[1], 1'b0, i[0]});
			settle();
			chk("alt", input_selector_alternate_set_o, i[1]);
			repeat (6) begin
				v = i[0] ? selector_sync_pulse_i : segment_pin_seven_lcd_i;
				@(posedge clk_i);
				chk("seven", segment_pin_seven_o, v);
			end
			bus(1'b1, mio_pkg::IDX_OPTICAL, 32'(i) << 5);
			settle();
			chk("oe", optical_transmit_pin_oe_o, !i[0]);
			v = optical_tx_data_i;
			@(posedge clk_i);
			chk("tx", optical_transmit_pin_o, v);
		end
		foreach (al_tbl[k]) begin
			bus(1'b1, mio_pkg::IDX_PIN_ALLOC, 32'(al_tbl[k]));
			settle();
			n = al_tbl[k] > 18 ? 18 : al_tbl[k];
			for (i = 0; i < 42; i++) sm[i] = i >= 42 - n;
			for (i = 0; i < 22; i++) gm[i] = i >= 4 && i <= 21 - n;
			chk("seg_en", segment_pin_enable_o, sm);
			chk("gpio_en", general_purpose_pin_enable_o, gm);
		end
		for (i = 0; i < 42; i++) begin
			seg_mem[i] = 4'($urandom);
			bus(1'b1, mio_pkg::IDX_SEG_FIRST + 14'(i), {28'h0, seg_mem[i]});
		end
		for (i = 0; i < 42; i += 5) rd(mio_pkg::IDX_SEG_FIRST + 14'(i), {28'h0, seg_mem[i]});
		for (k = 0; k < 4; k++) begin
			i = $urandom_range(41);
			lcd_seg_index_i <= 6'(i);
			lcd_commons_used_i <= 2'(k);
			settle();
			chk("lcd", lcd_seg_data_o, seg_mem[i] & 4'((1 << (k + 1)) - 1));
		end
		for (k = 0; k < 8; k++) begin
			bus(1'b1, mio_pkg::IDX_CPU_DIV, 32'(k));
			repeat (300) @(posedge clk_i);
			n = 0;
			repeat (256) begin
				@(posedge clk_i);
				n += int'(cpu_clock_enable_o);
			end
			chk("pulses", n, 256 >> k);
			rd(mio_pkg::IDX_CPU_DIV, 32'(k));
		end
		bus(1'b1, mio_pkg::IDX_CPU_DIV, 32'h2);
		bus(1'b1, mio_pkg::IDX_CPU_DIV, 32'h0);
		repeat (400) @(posedge clk_i);
		chk("enable", cpu_clock_enable_o, 1);
		end_of_test();
	end
endmodule
`default_nettype wire
